// [core/asc_cfg.svh]
// Offsets, field positions, reset values and timing counts of the converter
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
`define ASC_ADDR_CTL        8'h30
`define ASC_ADDR_FRQ        8'h31
`define ASC_ADDR_OPT        8'h39
`define ASC_ADDR_RES_BASE   8'h40
`define ASC_OPT_PWR_BIT     7
`define ASC_OPT_CONV_CLOCK_SELECT_BIT    6
`define ASC_FRQ_HALF_BIT    0
`define ASC_CTL_DONE_BIT    7
`define ASC_RESET_CTL       7'h00
`define ASC_LEVEL_HIGH      12'h3ff
`define ASC_LEVEL_HALF      12'h200
`define ASC_LEVEL_LOW       12'h000
`define ASC_FULL_CODE       10'h3ff
`define ASC_GROUP_E_CYCLES  144
`define ASC_CONV_TICKS      (`ASC_GROUP_E_CYCLES / 4)
`define ASC_CLK_KHZ         50000
`define ASC_RC_KHZ          1500
`define ASC_RC_DIV          (`ASC_CLK_KHZ / `ASC_RC_KHZ)
`endif

// [core/asc_pkg.sv]
// Types shared by the converter sequencer and its approximation engine
package asc_pkg;
    typedef enum logic [0:0] {SAR_IDLE, SAR_BUSY} asc_phase_e;

    typedef struct packed {
        logic [1:0][10:0][11:0] sync;
        logic                   eight;
        logic                   scan;
        logic                   multi_channel_select;
        logic [3:0]             chan;
        logic                   done;
        logic                   active;
        logic [2:0]             idx;
        logic                   pwr;
        logic                   conv_clock_select;
        logic                   half;
        logic [7:0][9:0]        res;
        logic [5:0]             div;
        logic                   tick;
        logic                   restart;
        logic [15:0]            rdata;
        logic [7:0]             gap;
        logic                   gap_ok;
    } asc_seq_s;

    typedef struct packed {
        asc_phase_e  phase;
        logic [5:0]  cnt;
        logic [11:0] sample;
        logic [9:0]  code;
        logic        done;
        logic [9:0]  result;
    } asc_sar_s;
endpackage : asc_pkg

// [core/asc_sar_if.sv]
// Link between the sequencer and the approximation engine
interface asc_sar_if;
    logic        tick;
    logic        run;
    logic        restart;
    logic [11:0] sample_val;
    logic        done;
    logic [9:0]  result;
    modport seq (output tick, run, restart, sample_val, input done, result);
    modport sar (input tick, run, restart, sample_val, output done, result);
endinterface : asc_sar_if

// [core/asc_sar_core.sv]
// Successive-approximation engine: sample, ten compare steps, result pulse
`include "asc_cfg.svh"
module asc_sar_core
    import asc_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    asc_sar_if.sar    sar
);
    localparam logic [5:0] LAST_CNT = 6'(`ASC_CONV_TICKS - 1);

    asc_sar_s s;
    asc_sar_s n;
    logic [9:0] trial;

    always_comb
    begin
        n = s;
        n.done = 1'b0;
        trial = s.code | (10'h001 << (4'(10) - s.cnt[3:0]));
        if (!sar.run || sar.restart)
        begin
            n.phase = sar.run ? SAR_BUSY : SAR_IDLE;
            n.cnt = 6'h00;
        end
        else
        begin
            n.phase = SAR_BUSY;
            if (sar.tick)
            begin
                if (s.cnt == 6'h00)
                begin
                    n.sample = sar.sample_val;
                    n.code = 10'h000;
                end
                else if (s.cnt <= 6'h0a && {2'b00, trial} <= s.sample)
                    n.code = trial;
                if (s.cnt == LAST_CNT)
                begin
                    n.done = 1'b1;
                    n.result = s.code;
                    n.cnt = 6'h00;
                end
                else
                    n.cnt = s.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            s <= '0;
        else
            s <= n;
    end

    assign sar.done = s.done;
    assign sar.result = s.result;

    sat_code_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s.done && s.sample >= `ASC_LEVEL_HIGH |-> s.result == `ASC_FULL_CODE)
        else $error("Over-range input did not saturate");
    approx_code_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s.done && s.sample < `ASC_LEVEL_HIGH |->
            {2'b00, s.result} <= s.sample
            && s.sample < {2'b00, s.result} + 12'h001)
        else $error("Approximation does not match sampled level");
endmodule : asc_sar_core

// [core/asc_sequence_control.sv]
// Converter sequencer: channel mux, sequencing, result and control registers
`include "asc_cfg.svh"
module asc_sequence_control
    import asc_pkg::*;
#(
    parameter int RC_DIV = `ASC_RC_DIV
)
(
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [7:0]       addr_in,
    input  wire logic [15:0]      wr_data_in,
    input  wire logic             wr_en_in,
    input  wire logic             rd_en_in,
    input  wire logic [9:0][11:0] analog_inputs_in,
    input  wire logic [11:0]      test_point_in,
    output logic      [15:0]      rd_data_out,
    output logic                  sequence_done_flag_out,
    output logic                  converter_active_out
);
    localparam logic [5:0] RC_LIM = 6'(RC_DIV - 1);

    asc_seq_s  s;
    asc_seq_s  n;
    asc_sar_if sar_bus ();

    // Mux level for a channel code
    function automatic logic [11:0] chan_level(
        input logic [10:0][11:0] lv,
        input logic [3:0]        ch
    );
        logic [11:0] v;
        v = `ASC_LEVEL_LOW;
        if (!ch[3])
            v = lv[4'(ch[2:0]) + 4'h2];
        else if (ch[3:1] == 3'b100)
            v = lv[{3'b000, ch[0]}];
        else if (ch == 4'hc)
            v = `ASC_LEVEL_HIGH;
        else if (ch == 4'he)
            v = `ASC_LEVEL_HALF;
        else if (ch == 4'hf)
            v = lv[10];
        return v;
    endfunction : chan_level

    // Channel converted at step idx
    function automatic logic [3:0] conv_chan(input asc_seq_s c);
        if (!c.multi_channel_select)
            return c.chan;
        else if (c.eight)
            return {c.chan[3], c.idx};
        else
            return {c.chan[3:2], c.idx[1:0]};
    endfunction : conv_chan

    // Result slot of step idx, 0 for register one
    function automatic logic [2:0] dest_slot(input asc_seq_s c);
        return c.eight ? c.idx : {1'b1, c.idx[1:0]};
    endfunction : dest_slot

    function automatic logic is_result(input logic [7:0] a);
        return a[7:3] == 5'(`ASC_ADDR_RES_BASE >> 3);
    endfunction : is_result

    function automatic logic [15:0] reg_read(
        input asc_seq_s   c,
        input logic [7:0] a
    );
        logic [15:0] d;
        d = 16'h0000;
        if (is_result(a))
            d = {c.res[a[2:0]], 6'h00};
        else if (a == `ASC_ADDR_CTL)
            d = {8'h00, c.done, c.eight, c.scan, c.multi_channel_select, c.chan};
        else if (a == `ASC_ADDR_OPT)
            d = 16'({c.pwr, c.conv_clock_select}) << `ASC_OPT_CONV_CLOCK_SELECT_BIT;
        else if (a == `ASC_ADDR_FRQ)
            d = 16'(c.half) << `ASC_FRQ_HALF_BIT;
        return d;
    endfunction : reg_read

    always_comb
    begin
        n = s;
        n.sync[0] = {test_point_in, analog_inputs_in};
        n.sync[1] = s.sync[0];
        n.restart = 1'b0;
        n.rdata = 16'h0000;
        // Conversion clock enable
        if (s.div >= (s.conv_clock_select ? RC_LIM : (s.half ? 6'h01 : 6'h00)))
        begin
            n.div = 6'h00;
            n.tick = 1'b1;
        end
        else
        begin
            n.div = s.div + 6'h01;
            n.tick = 1'b0;
        end
        // Store one result per conversion, every 36 conversion clock ticks
        if (sar_bus.done && s.active && !s.restart)
        begin
            n.res[dest_slot(s)] = sar_bus.result;
            n.idx = s.idx + 3'h1;
            if (s.idx == (s.eight ? 3'h7 : 3'h3))
            begin
                n.idx = 3'h0;
                n.done = 1'b1;
                n.active = s.scan;
            end
        end
        if (wr_en_in)
        begin
            if (addr_in == `ASC_ADDR_CTL)
            begin
                {n.eight, n.scan, n.multi_channel_select, n.chan} = wr_data_in[6:0];
                n.done = 1'b0;
                n.idx = 3'h0;
                n.active = s.pwr;
                n.restart = 1'b1;
            end
            else if (addr_in == `ASC_ADDR_OPT)
            begin
                n.pwr = wr_data_in[`ASC_OPT_PWR_BIT];
                n.conv_clock_select = wr_data_in[`ASC_OPT_CONV_CLOCK_SELECT_BIT];
            end
            else if (addr_in == `ASC_ADDR_FRQ)
                n.half = wr_data_in[`ASC_FRQ_HALF_BIT];
        end
        if (!n.pwr)
            n.active = 1'b0;
        if (rd_en_in)
            n.rdata = reg_read(s, addr_in);
        // Spacing between results, for checking only
        n.gap = (s.gap == 8'hff) ? s.gap : s.gap + 8'h01;
        if (sar_bus.done || s.restart)
            n.gap = 8'h00;
        if (sar_bus.done && s.active)
            n.gap_ok = 1'b1;
        if (s.restart || wr_en_in || !s.active)
            n.gap_ok = 1'b0;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            s <= '0;
        else
            s <= n;
    end

    assign sar_bus.tick = s.tick;
    assign sar_bus.run = s.active;
    assign sar_bus.restart = s.restart;
    // Next index: a sample taken as a result lands is for the coming channel
    assign sar_bus.sample_val = chan_level(s.sync[1], conv_chan(n));

    asc_sar_core u_sar (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .sar        (sar_bus.sar)
    );

    assign rd_data_out = s.rdata;
    assign sequence_done_flag_out = s.done;
    assign converter_active_out = s.active;

    full_rate_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        sar_bus.done && s.gap_ok && !s.conv_clock_select && !s.half |-> s.gap == 8'd35)
        else $error("Full-rate conversion not 36 cycles");
    half_rate_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        sar_bus.done && s.gap_ok && !s.conv_clock_select && s.half |-> s.gap == 8'd71)
        else $error("Half-rate conversion not 72 cycles");
    low_bits_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        rd_en_in && is_result(addr_in) |=> rd_data_out[5:0] == 6'h00)
        else $error("Result low bits not zero");
    write_clears_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        wr_en_in && addr_in == `ASC_ADDR_CTL
            |=> !sequence_done_flag_out && s.idx == 3'h0)
        else $error("Control write did not clear flag");
    power_abort_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !s.pwr |=> !converter_active_out)
        else $error("Converter active while powered off");
    no_start_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        wr_en_in && addr_in == `ASC_ADDR_CTL && !s.pwr
            |=> !converter_active_out [*2])
        else $error("Sequence started while powered off");
    single_stop_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        $rose(sequence_done_flag_out) && !s.scan |-> !converter_active_out)
        else $error("Single scan did not stop");
    done_holds_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        sequence_done_flag_out && !(wr_en_in && addr_in == `ASC_ADDR_CTL)
            |=> sequence_done_flag_out)
        else $error("Done flag dropped without control write");
    slot_four_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        sar_bus.done && s.active && !s.eight |-> dest_slot(s) >= 3'h4)
        else $error("Four-mode result outside registers 5-8");
    mux_reserved_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s.active && !s.multi_channel_select && !wr_en_in && s.chan inside {4'ha, 4'hb, 4'hd}
            |-> sar_bus.sample_val == `ASC_LEVEL_LOW)
        else $error("Reserved channel not tied to low level");
    pass_length_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        $rose(sequence_done_flag_out)
            |-> $past(s.idx) == (s.eight ? 3'h7 : 3'h3))
        else $error("Pass length not four or eight results");
    idx_range_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        s.active && !s.eight |-> s.idx <= 3'h3)
        else $error("Four-mode index beyond fourth result");
    done_idx_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        $rose(sequence_done_flag_out) |-> s.idx == 3'h0)
        else $error("Done flag set before pass wrapped");
    scan_runs_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        $rose(sequence_done_flag_out) && s.scan && s.pwr
            |-> converter_active_out)
        else $error("Continuous scan stopped after a pass");
    stop_holds_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !converter_active_out && !(wr_en_in && addr_in == `ASC_ADDR_CTL)
            |=> !converter_active_out)
        else $error("Sequence started without control write");
    ctl_store_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        wr_en_in && addr_in == `ASC_ADDR_CTL
            |=> {s.eight, s.scan, s.multi_channel_select, s.chan} == $past(wr_data_in[6:0]))
        else $error("Control write settings not taken");
    write_start_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        wr_en_in && addr_in == `ASC_ADDR_CTL && s.pwr
            |=> converter_active_out && sar_bus.restart)
        else $error("Control write did not start a sequence");
    full_tick_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !s.conv_clock_select && !s.half |=> sar_bus.tick)
        else $error("Full-rate conversion clock missed a cycle");
    half_tick_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        sar_bus.tick && !s.conv_clock_select && s.half |=> !sar_bus.tick)
        else $error("Half-rate conversion clock ran too fast");
    osc_tick_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        RC_DIV > 1 && sar_bus.tick && s.conv_clock_select |=> !sar_bus.tick)
        else $error("Oscillator conversion clock ran too fast");
    one_store_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        sar_bus.done |=> !sar_bus.done)
        else $error("Two results offered in successive cycles");
    power_idle_a: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        !s.pwr |-> !sar_bus.run)
        else $error("Approximation engine running while powered off");

    // Each result register changes only when its own slot is stored
    generate
        for (genvar g = 0; g < 8; g++)
        begin : g_slot
            slot_hold_a: assert property (@(posedge clk_in)
                disable iff (!reset_n_in)
                !(sar_bus.done && s.active && !s.restart
                    && dest_slot(s) == 3'(g)) |=> $stable(s.res[g]))
                else $error("Result register changed without a store");
        end
    endgenerate

    single_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(sequence_done_flag_out) && !s.scan && !s.multi_channel_select);
    multi8_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(sequence_done_flag_out) && s.multi_channel_select && s.eight);
    wrap_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        sar_bus.done && s.scan && sequence_done_flag_out);
    rc_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        sar_bus.done && s.conv_clock_select);
    half_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(sequence_done_flag_out) && s.half);
endmodule : asc_sequence_control

// [test/asc_sequence_control_tb.sv]
// Self-checking bench for the converter sequencer
`include "asc_cfg.svh"
module asc_sequence_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clk_in;
    logic             reset_n_in;
    logic             wr_en_in;
    logic             rd_en_in;
    logic [7:0]       addr_in;
    logic [15:0]      wr_data_in;
    logic [15:0]      rd_data_out;
    logic [9:0][11:0] ain;
    logic [11:0]      tp;
    logic             done_o;
    logic             act_o;
    int               n_errors;
    int               tests_run;
    int               cyc;
    int               n;
    int               i;
    int               r;
    // Power-on settling, about 100 us of 20 ns cycles
    localparam int    SETTLE_CYCLES = 5000;
    // Control words: single codes, single eight, multi groups
    logic [7:0]       rows [24] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
        8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
        8'h0e, 8'h0f, 8'h40, 8'h47, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h50,
        8'h58};

    asc_sequence_control #(.RC_DIV(2)) u_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .analog_inputs_in(ain),
        .test_point_in(tp), .rd_data_out(rd_data_out),
        .sequence_done_flag_out(done_o), .converter_active_out(act_o));

    // Expected result word of one channel code
    function automatic logic [15:0] lvl(input logic [3:0] c);
        logic [11:0] v;
        v = `ASC_LEVEL_LOW;
        if (c < 4'h8)
            v = ain[c + 4'h2];
        else if (c < 4'ha)
            v = ain[c - 4'h8];
        else if (c == 4'hc)
            v = `ASC_LEVEL_HIGH;
        else if (c == 4'he)
            v = `ASC_LEVEL_HALF;
        else if (c == 4'hf)
            v = tp;
        if (v > `ASC_LEVEL_HIGH)
            v = `ASC_LEVEL_HIGH;
        return {v[9:0], 6'h00};
    endfunction : lvl

    // Expected content of result register k for a control word
    function automatic logic [15:0] ereg(input logic [7:0] c,
                                         input logic [3:0] k);
        logic [3:0] m;
        m = k - 4'h1;
        if (!c[4])
            return lvl(c[3:0]);
        if (c[6])
            return lvl({c[3], m[2:0]});
        return lvl({c[3:2], m[1:0]});
    endfunction : ereg

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1;
        chk(rd_data_out, e);
    endtask : rd

    task automatic idle(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask : idle

    task automatic wdone(output int k);
        k = 0;
        while (done_o !== 1'b1 && k < 3000)
        begin
            idle(1);
            k++;
        end
    endtask : wdone

    task automatic flags(input logic [1:0] e);
        chk({14'h0000, done_o, act_o}, {14'h0000, e});
    endtask : flags

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Hang guard
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            results();
        end
    end

    initial
    begin
        reset_n_in = 1'b0;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        addr_in = 8'h00;
        wr_data_in = 16'h0000;
        tp = 12'h155;
        for (i = 0; i < 10; i++)
            ain[i] = 12'h013 + 12'(i) * 12'h05d;
        ain[9] = 12'h7ff;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        idle(1);
        flags(2'b00);
        rd(`ASC_ADDR_CTL, 16'h0000);
        rd(`ASC_ADDR_OPT, 16'h0000);
        $display("test reset finished");
        wr(`ASC_ADDR_CTL, 16'h0000);
        idle(100);
        flags(2'b00);
        $display("test power_off_start finished");
        wr(`ASC_ADDR_OPT, 16'h0080);
        idle(SETTLE_CYCLES);
        rd(`ASC_ADDR_OPT, 16'h0080);
        for (r = 0; r < 24; r++)
        begin
            wr(`ASC_ADDR_CTL, {8'h00, rows[r]});
            chk({15'h0000, done_o}, 16'h0000);
            wdone(n);
            flags(2'b10);
            rd(`ASC_ADDR_CTL, {8'h00, 1'b1, rows[r][6:0]});
            for (i = rows[r][6] ? 1 : 5; i <= 8; i++)
                rd(`ASC_ADDR_RES_BASE + 8'(i - 1), ereg(rows[r], 4'(i)));
        end
        $display("test table finished");
        wr(`ASC_ADDR_CTL, 16'h0004);
        wdone(n);
        chk({15'h0000, n inside {[140:152]}}, 16'h0001);
        wr(`ASC_ADDR_FRQ, 16'h0001);
        wr(`ASC_ADDR_CTL, 16'h0004);
        wdone(n);
        chk({15'h0000, n inside {[284:300]}}, 16'h0001);
        wr(`ASC_ADDR_FRQ, 16'h0000);
        $display("test rate finished");
        wr(`ASC_ADDR_CTL, 16'h0000);
        idle(60);
        wr(`ASC_ADDR_CTL, 16'h0001);
        flags(2'b01);
        wdone(n);
        chk({15'h0000, n inside {[140:152]}}, 16'h0001);
        $display("test abort_write finished");
        wr(`ASC_ADDR_CTL, 16'h0024);
        wdone(n);
        flags(2'b11);
        ain[6] = 12'h0ab;
        idle(400);
        flags(2'b11);
        for (i = 5; i <= 8; i++)
            rd(`ASC_ADDR_RES_BASE + 8'(i - 1), ereg(8'h24, 4'(i)));
        $display("test continuous finished");
        wr(`ASC_ADDR_CTL, 16'h0000);
        idle(20);
        wr(`ASC_ADDR_OPT, 16'h0000);
        idle(3);
        chk({15'h0000, act_o}, 16'h0000);
        idle(300);
        flags(2'b00);
        $display("test power_abort finished");
        wr(`ASC_ADDR_OPT, 16'h00c0);
        idle(SETTLE_CYCLES);
        wr(`ASC_ADDR_CTL, 16'h0005);
        wdone(n);
        chk({15'h0000, n inside {[284:400]}}, 16'h0001);
        for (i = 5; i <= 8; i++)
            rd(`ASC_ADDR_RES_BASE + 8'(i - 1), ereg(8'h05, 4'(i)));
        $display("test osc_clock finished");
        wr(`ASC_ADDR_CTL, 16'h0025);
        idle(50);
        reset_n_in <= 1'b0;
        idle(2);
        reset_n_in <= 1'b1;
        idle(1);
        flags(2'b00);
        rd(`ASC_ADDR_OPT, 16'h0000);
        rd(`ASC_ADDR_CTL, 16'h0000);
        rd(`ASC_ADDR_RES_BASE + 8'h04, 16'h0000);
        $display("test mid_reset finished");
        rd(8'h50, 16'h0000);
        idle(1);
        chk(rd_data_out, 16'h0000);
        $display("test unmapped finished");
        results();
    end
endmodule : asc_sequence_control_tb
